// [verilog/acc_top.sv]
`timescale 1ns/10ps
// Contract
// RULE1: scl and sda are only pulled low or released, never driven high.
// RULE2: calibration memory is a 512 x 8 two-wire device, byte addressed.
// RULE3: one 16-bit offset and gain word is read per channel.
// RULE4: correction words are signed two's complement, -32768 to +32767.
// RULE5: each channel of a dual converter has its own offset and gain.
// RULE6: channel one bytes at 0x000: offset hi, offset lo, gain hi, gain lo.
// RULE7: following channels use next four bytes; channel 24 spans 0x05C to 0x05F.
// RULE8: 24 channels from 12 dual converters, each with its own context.
// RULE9: stored values are quarter LSB; offset is divided by four.
// RULE10: scaled offset is subtracted from the gain-adjusted sample.
// RULE11: gain corrected by multiplying the sample by a per-channel factor.
// RULE12: value = sample * (1 - gain / 131072) - offset / 4.
// RULE13: the full 16-bit raw word is the sample operand.
// RULE14: scaled integer math, no rounding before the final result.
// RULE15: every channel sustains one corrected sample per conversion at 5 Msps.
// RULE16: raw samples are signed, 0x7FFF full positive, 0x8000 full negative.
// RULE17: both samples of a converter are accepted and corrected together.
// RULE18: all 96 bytes load after reset; samples flagged uncorrected until then.
// RULE19: corrected results saturate to the signed 16-bit range.
// RULE20: lower address byte is the high half of each word.
module acc_top
  import acc_pkg::*;
#(
  parameter int QTR_CYC = I2C_QTR
) (
  // system clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_arst_n,
  // sample link, link clock domain
  input  wire logic       i_lnk_clk,
  input  wire logic       i_frame_valid,
  input  wire acc_frame_t i_frame,
  output logic            o_lnk_ready,
  // corrected samples, two per cycle
  output logic            o_smp_valid,
  output acc_smp_t [1:0]  o_smp,
  output logic            o_cal_loaded,
  // calibration memory, open-drain pins
  input  wire logic       i_scl,
  output logic            o_scl_o,
  output logic            o_scl_oe,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  acc_i2c_st_t          st_q;
  logic [11:0]          div_q;
  logic [1:0]           ph_q;
  logic                 tick;
  logic                 scl_low_q;
  logic                 sda_low_q;
  logic                 scl_s1_q, scl_s2_q;
  logic                 sda_s1_q, sda_s2_q;
  logic [3:0]           bit_q;
  logic [1:0]           sel_q;
  logic                 rd_q;
  logic                 nack_q;
  logic                 retry_q;
  logic [7:0]           tx_q;
  logic [7:0]           rx_q;
  logic [6:0]           idx_q;
  logic                 done_q;
  logic [15:0]          ofs_q  [NUM_CH];
  logic [15:0]          gain_q [NUM_CH];
  logic                 lreq_q;
  logic                 lack_s1_q, lack_s2_q;
  acc_frame_t           hold_q;
  logic                 req_s1_q, req_s2_q;
  logic                 ack_q;
  acc_frame_t           frm_q;
  logic                 run_q;
  logic [PAIR_W-1:0]    pair_q;
  logic                 vld_q;
  logic                 corr_q;
  logic [1:0][4:0]      chan_q;
  logic [1:0][15:0]     data_w;

  // ----------------------------------------------------------------
  // open-drain pins
  // ----------------------------------------------------------------
  assign o_scl_o      = 1'b0;                                            // RULE1
  assign o_sda_o      = 1'b0;                                            // RULE1
  assign o_scl_oe     = scl_low_q;                                       // RULE1
  assign o_sda_oe     = sda_low_q;                                       // RULE1
  assign o_cal_loaded = done_q;

  // pin synchronisers
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      scl_s1_q <= i_scl;
      scl_s2_q <= scl_s1_q;
      sda_s1_q <= i_sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // quarter-bit timer, holds while the slave stretches scl
  // ----------------------------------------------------------------
  // stretch is only seen in the quarter after scl is released
  assign tick = (div_q == 12'(QTR_CYC - 1)) && !(ph_q == 2'd2 && !scl_s2_q);

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q <= 12'h000;
    end else if (st_q == ST_BOOT || st_q == ST_DONE || tick) begin
      div_q <= 12'h000;
    end else if (div_q != 12'(QTR_CYC - 1)) begin
      div_q <= div_q + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // two-wire master: random read of the table from its base address
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q      <= ST_BOOT;
      ph_q      <= 2'd0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      bit_q     <= 4'h0;
      sel_q     <= 2'd0;
      rd_q      <= 1'b0;
      nack_q    <= 1'b0;
      retry_q   <= 1'b0;
      tx_q      <= 8'h00;
      rx_q      <= 8'h00;
      idx_q     <= 7'h00;
      done_q    <= 1'b0;
    end else begin
      case (st_q)
        ST_BOOT: begin
          st_q  <= ST_START;
          ph_q  <= 2'd0;
          sel_q <= 2'd0;
          idx_q <= 7'h00;
          rd_q  <= 1'b0;
        end
        // start or repeated start
        ST_START: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: sda_low_q <= 1'b0;
            2'd1: scl_low_q <= 1'b0;
            2'd2: sda_low_q <= 1'b1;
            default: begin
              scl_low_q <= 1'b1;
              st_q      <= ST_BIT;
              bit_q     <= 4'h0;
              tx_q      <= (sel_q == 2'd0) ? EE_DEV_WR : EE_DEV_RD;        // RULE2
            end
          endcase
        end
        // one data bit or acknowledge slot
        ST_BIT: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: begin
              if (bit_q != 4'h8) begin
                sda_low_q <= rd_q ? 1'b0 : ~tx_q[7];
              end else begin
                sda_low_q <= rd_q && (idx_q != LAST_BYTE);             // nack on last
              end
            end
            2'd1: scl_low_q <= 1'b0;
            2'd2: begin
              if (bit_q != 4'h8) begin
                rx_q <= {rx_q[6:0], sda_s2_q};
              end else begin
                nack_q <= sda_s2_q;
              end
            end
            default: begin
              scl_low_q <= 1'b1;
              if (bit_q != 4'h8) begin
                bit_q <= bit_q + 4'h1;
                tx_q  <= {tx_q[6:0], 1'b0};
              end else if (rd_q) begin
                bit_q <= 4'h0;
                idx_q <= idx_q + 7'h01;                                  // RULE7
                if (idx_q == LAST_BYTE) begin
                  st_q    <= ST_STOP;                                    // RULE18
                  retry_q <= 1'b0;
                end
              end else if (nack_q) begin
                st_q    <= ST_STOP;
                retry_q <= 1'b1;
              end else if (sel_q == 2'd0) begin
                sel_q <= 2'd1;
                bit_q <= 4'h0;
                tx_q  <= EE_TBL_BASE;                                    // RULE6
              end else if (sel_q == 2'd1) begin
                sel_q <= 2'd2;
                st_q  <= ST_START;
              end else begin
                rd_q  <= 1'b1;
                bit_q <= 4'h0;
              end
            end
          endcase
        end
        // stop, then retry or finish
        ST_STOP: if (tick) begin
          ph_q <= ph_q + 2'd1;
          case (ph_q)
            2'd0: sda_low_q <= 1'b1;
            2'd1: scl_low_q <= 1'b0;
            2'd2: sda_low_q <= 1'b0;
            default: begin
              if (retry_q) begin
                st_q  <= ST_START;
                sel_q <= 2'd0;
                idx_q <= 7'h00;
                rd_q  <= 1'b0;
              end else begin
                st_q   <= ST_DONE;
                done_q <= 1'b1;                                          // RULE18
              end
            end
          endcase
        end
        ST_DONE: st_q <= ST_DONE;
        default: st_q <= ST_BOOT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // coefficient store, one context per channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ofs_q[c]  <= COEF_RST;
        gain_q[c] <= COEF_RST;
      end
    end else if (st_q == ST_BIT && tick && ph_q == 2'd3 && rd_q && bit_q == 4'h8) begin
      case (idx_q[1:0])                                                  // RULE6 RULE7
        FLD_OFS_HI:  ofs_q[idx_q[6:2]][15:8]  <= rx_q;                   // RULE20 RULE3
        FLD_OFS_LO:  ofs_q[idx_q[6:2]][7:0]   <= rx_q;                   // RULE20
        FLD_GAIN_HI: gain_q[idx_q[6:2]][15:8] <= rx_q;                   // RULE20 RULE5
        default:     gain_q[idx_q[6:2]][7:0]  <= rx_q;                   // RULE20
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link domain: hold a frame and raise a request toggle
  // ----------------------------------------------------------------
  assign o_lnk_ready = (lreq_q == lack_s2_q);

  always_ff @(posedge i_lnk_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lreq_q    <= 1'b0;
      lack_s1_q <= 1'b0;
      lack_s2_q <= 1'b0;
      hold_q    <= '0;
    end else begin
      lack_s1_q <= ack_q;
      lack_s2_q <= lack_s1_q;
      if (i_frame_valid && o_lnk_ready) begin
        hold_q <= i_frame;                                               // RULE17
        lreq_q <= ~lreq_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // reference domain: take the held frame, walk it pair by pair
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_q    <= 1'b0;
      frm_q    <= '0;
      run_q    <= 1'b0;
      pair_q   <= '0;
    end else begin
      req_s1_q <= lreq_q;
      req_s2_q <= req_s1_q;
      if (!run_q && req_s2_q != ack_q) begin
        frm_q  <= hold_q;
        ack_q  <= ~ack_q;
        run_q  <= 1'b1;
        pair_q <= '0;
      end else if (run_q) begin
        // stop on the last pair so the lane index never leaves the frame
        if (pair_q == PAIR_W'(NUM_ADC - 1)) begin
          run_q <= 1'b0;
        end else begin
          pair_q <= pair_q + 1'b1;                                       // RULE15
        end
      end
    end
  end

  // output tags aligned with the corrector register
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vld_q  <= 1'b0;
      corr_q <= 1'b0;
      chan_q <= '0;
    end else begin
      vld_q  <= run_q;
      corr_q <= done_q;                                                  // RULE18
      chan_q <= {{pair_q, 1'b1}, {pair_q, 1'b0}};                        // RULE8
    end
  end

  // ----------------------------------------------------------------
  // two correction lanes, one per channel of a converter
  // ----------------------------------------------------------------
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [4:0] ch;
    assign ch = {pair_q, 1'(l)};
    acc_corrector u_corr (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_sample  (frm_q[ch]),                                            // RULE13
      .i_ofs     (done_q ? ofs_q[ch] : COEF_RST),                        // RULE5 RULE18
      .i_gain    (done_q ? gain_q[ch] : COEF_RST),
      .o_data    (data_w[l])
    );
    assign o_smp[l] = '{chan: chan_q[l], corrected: corr_q, data: data_w[l]};
  end

  assign o_smp_valid = vld_q;

endmodule

// [verilog/acc_pkg.sv]
package acc_pkg;

  // ----------------------------------------------------------------
  // channel organisation
  // ----------------------------------------------------------------
  localparam int NUM_CH        = 24;
  localparam int NUM_ADC       = 12;
  localparam int LANES         = 2;              // channels per converter
  localparam int SMP_W         = 16;

  // ----------------------------------------------------------------
  // calibration memory layout (512 x 8, byte addressed)
  // ----------------------------------------------------------------
  localparam int       EE_SIZE_BYTES = 512;
  localparam int       CAL_BYTES     = 96;       // 24 channels x 4 bytes
  localparam int       BYTES_PER_CH  = 4;
  localparam logic [7:0] EE_DEV_WR   = 8'hA0;    // device select, write, A8 = 0
  localparam logic [7:0] EE_DEV_RD   = 8'hA1;    // device select, read, A8 = 0
  localparam logic [7:0] EE_TBL_BASE = 8'h00;    // first table byte
  localparam logic [1:0] FLD_OFS_HI  = 2'h0;
  localparam logic [1:0] FLD_OFS_LO  = 2'h1;
  localparam logic [1:0] FLD_GAIN_HI = 2'h2;
  localparam logic [1:0] FLD_GAIN_LO = 2'h3;
  localparam logic [6:0] LAST_BYTE   = 7'h5F;
  localparam logic [15:0] COEF_RST   = 16'h0000; // identity correction

  // ----------------------------------------------------------------
  // correction arithmetic
  // ----------------------------------------------------------------
  localparam int GAIN_SHIFT = 17;                 // gain word / 131072
  localparam logic signed [18:0] GAIN_ONE  = 19'sh20000;
  localparam int OFS_SHIFT  = 15;                 // offset / 4 at 2^17 scale
  localparam logic signed [35:0] RND_HALF  = 36'sh000010000;
  localparam logic signed [18:0] SAT_POS   = 19'sh07FFF;
  localparam logic signed [18:0] SAT_NEG   = -19'sh08000;
  localparam logic [15:0] FS_POS = 16'h7FFF;
  localparam logic [15:0] FS_NEG = 16'h8000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ = 100_000_000;
  localparam int I2C_HZ     = 100_000;
  localparam int I2C_QTR    = REF_CLK_HZ / (4 * I2C_HZ); // quarter bit, cycles
  localparam int PAIR_W     = 4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef logic [NUM_CH-1:0][SMP_W-1:0] acc_frame_t;

  typedef struct packed {
    logic [4:0]       chan;
    logic             corrected;
    logic [SMP_W-1:0] data;
  } acc_smp_t;

  typedef enum logic [2:0] {ST_BOOT, ST_START, ST_BIT, ST_STOP, ST_DONE} acc_i2c_st_t;

endpackage

// [verilog/acc_corrector.sv]
`timescale 1ns/10ps
module acc_corrector
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_arst_n,
  // operands
  input  wire logic [SMP_W-1:0] i_sample,
  input  wire logic [15:0]      i_ofs,
  input  wire logic [15:0]      i_gain,
  // result
  output logic [SMP_W-1:0]      o_data
);

  // ----------------------------------------------------------------
  // scaled integer arithmetic, 2^17 fraction
  // ----------------------------------------------------------------
  logic signed [18:0] factor;
  logic signed [35:0] prod;
  logic signed [35:0] ofs_term;
  logic signed [35:0] acc;
  logic signed [18:0] res;
  logic [SMP_W-1:0]   data_d;

  // gain factor (1 - g/131072) held as 131072 - g
  assign factor   = GAIN_ONE - $signed({{3{i_gain[15]}}, i_gain});       // RULE4 RULE11
  // whole 16-bit raw word, signed
  assign prod     = $signed({{20{i_sample[15]}}, i_sample}) *
                    $signed({{17{factor[18]}}, factor});                 // RULE13 RULE16
  // offset / 4 expressed at the same scale
  assign ofs_term = $signed({{5{i_ofs[15]}}, i_ofs, 15'h0000});          // RULE9
  // subtract offset, round once at the very end
  assign acc      = prod - ofs_term + RND_HALF;                          // RULE10 RULE12 RULE14
  assign res      = acc[35:17];

  // clamp to 16-bit two's complement range
  always_comb begin
    if (res > SAT_POS) begin
      data_d = FS_POS;                                                   // RULE19
    end else if (res < SAT_NEG) begin
      data_d = FS_NEG;                                                   // RULE19
    end else begin
      data_d = res[15:0];
    end
  end

  // registered result
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data <= 16'h0000;
    end else begin
      o_data <= data_d;
    end
  end

endmodule

// [verif/acc_top_chk.sv]
`timescale 1ns/10ps
module acc_top_chk
  import acc_pkg::*;
#(
  parameter int QTR_CYC = I2C_QTR
) (
  // clocks and reset
  input wire logic           i_ref_clk,
  input wire logic           i_arst_n,
  input wire logic           i_lnk_clk,
  // sample link
  input wire logic           i_frame_valid,
  input wire acc_frame_t     i_frame,
  input wire logic           o_lnk_ready,
  // corrected samples
  input wire logic           o_smp_valid,
  input wire acc_smp_t [1:0] o_smp,
  input wire logic           o_cal_loaded,
  // memory pins
  input wire logic           i_scl,
  input wire logic           o_scl_o,
  input wire logic           o_scl_oe,
  input wire logic           i_sda,
  input wire logic           o_sda_o,
  input wire logic           o_sda_oe
);
  // ------------------------------------------------
  // helper logic
  // ------------------------------------------------
  // shortest table load: 96 bytes of 9 bits of 4 quarters
  localparam logic [31:0] MIN_LOAD = 32'(96 * 9 * 4 * QTR_CYC);
  logic [31:0] cyc_q;

  // cycles since reset release
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cyc_q <= 32'h0;
    end else begin
      cyc_q <= cyc_q + 32'h1;
    end
  end

  // twelve lane pairs, then a gap
  sequence s_burst;
    o_smp_valid [*8] ##1 o_smp_valid [*4] ##1 !o_smp_valid;
  endsequence

  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  a_pins_open_drain:
  assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    !o_scl_o && !o_sda_o) else $error("memory pin driven high");
  a_bus_free_loaded:
  assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_cal_loaded |-> !o_scl_oe && !o_sda_oe) else $error("bus held after load");
  a_burst_len:
  assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(o_smp_valid) |-> s_burst) else $error("burst not twelve cycles");
  a_chan_first:
  assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(o_smp_valid) |-> o_smp[0].chan == 5'h0 && o_smp[1].chan == 5'h1)
    else $error("burst does not start at channel one");
  a_chan_step:
  assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_smp_valid && $past(o_smp_valid) |-> o_smp[0].chan == $past(o_smp[0].chan) + 5'h2)
    else $error("channel step wrong");
  a_lane_pair:
  assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_smp_valid |-> o_smp[1].chan == o_smp[0].chan + 5'h1) else $error("lane pair wrong");
  a_flag_early:
  assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_smp_valid && !o_cal_loaded |-> !o_smp[0].corrected && !o_smp[1].corrected)
    else $error("corrected flag before load");
  a_load_sticky:
  assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_cal_loaded |=> o_cal_loaded) else $error("load flag dropped");
  a_load_time:
  assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(o_cal_loaded) |-> cyc_q >= MIN_LOAD) else $error("load too short");
  a_ready_drop:
  assert property (@(posedge i_lnk_clk) disable iff (!i_arst_n)
    i_frame_valid && o_lnk_ready |=> !o_lnk_ready) else $error("ready after take");
endmodule

bind acc_top acc_top_chk #(.QTR_CYC(QTR_CYC)) u_chk (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_lnk_clk(i_lnk_clk),
  .i_frame_valid(i_frame_valid), .i_frame(i_frame), .o_lnk_ready(o_lnk_ready),
  .o_smp_valid(o_smp_valid), .o_smp(o_smp), .o_cal_loaded(o_cal_loaded),
  .i_scl(i_scl), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
  .i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe)
);

// [verif/acc_eeprom_model.sv]
`timescale 1ns/10ps
module acc_eeprom_model
  import acc_pkg::*;
(
  // wire levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // open-drain pulls
  output logic      o_scl_low,
  output logic      o_sda_low
);
  logic [7:0] mem [0:EE_SIZE_BYTES-1];
  logic [7:0] sh      = 8'h00;
  logic [8:0] ptr     = 9'h000;
  logic       act     = 1'b0;
  logic       rd      = 1'b0;
  logic       first   = 1'b0;
  int         cnt     = 0;
  int         nread   = 0;
  int         refuse  = 0;
  int         stretch = 0;

  initial o_scl_low = 1'b0;
  initial o_sda_low = 1'b0;

  // start and stop conditions
  always @(negedge i_sda) begin
    if (i_scl) begin
      act = 1'b1;
      rd = 1'b0;
      first = 1'b1;
      cnt = 0;
    end
  end
  always @(posedge i_sda) begin
    if (i_scl) act = 1'b0;
  end

  // slow answer: hold the clock low a while
  always @(negedge i_scl) begin
    if (stretch > 0) begin
      o_scl_low = 1'b1;
      #(stretch) o_scl_low = 1'b0;
    end
  end

  // shift in on rising clock, ninth bit is the acknowledge
  always @(posedge i_scl) begin
    if (act && cnt < 8) begin
      sh = {sh[6:0], i_sda};
      cnt++;
    end else if (act) begin
      cnt = 0;
      if (rd && i_sda) act = 1'b0;
    end
  end

  // drive acknowledge or read data while the clock is low
  always @(negedge i_scl) begin
    o_sda_low = 1'b0;
    if (act && cnt == 8 && rd) begin
      ptr = ptr + 9'h001;
      nread++;
    end else if (act && cnt == 8 && first) begin
      first = 1'b0;
      if (sh[7:2] == EE_DEV_WR[7:2] && refuse == 0) begin
        o_sda_low = 1'b1;
        rd = sh[0];
        ptr[8] = sh[1];
      end else begin
        act = 1'b0;
        if (refuse > 0) refuse--;
      end
    end else if (act && cnt == 8) begin
      o_sda_low = 1'b1;
      ptr[7:0] = sh;
    end else if (act && rd) begin
      o_sda_low = !mem[ptr][7-cnt];
    end
  end
endmodule

// [verif/acc_top_bench.sv]
`timescale 1ns/10ps
module acc_top_bench
  import acc_pkg::*;
;
  logic           i_ref_clk     = 1'b0;
  logic           i_lnk_clk     = 1'b0;
  logic           i_arst_n      = 1'b0;
  logic           i_frame_valid = 1'b0;
  acc_frame_t     i_frame       = '0;
  logic           o_lnk_ready, o_smp_valid, o_cal_loaded;
  acc_smp_t [1:0] o_smp;
  logic           o_scl_o, o_scl_oe, o_sda_o, o_sda_oe, ee_scl_low, ee_sda_low;
  logic           scl_w, sda_w;
  logic [7:0]     cal [0:95];
  acc_frame_t     fq [$];
  logic           eq [$];
  int             fail_count = 0;
  int             num_checks = 0;
  int             seed       = 32'hfa34;
  int             cyc        = 0;
  int             k          = 0;

  // clocks and pulled-up open-drain wires
  always #5 i_ref_clk = ~i_ref_clk;
  always #16 i_lnk_clk = ~i_lnk_clk;
  assign scl_w = !(o_scl_oe || ee_scl_low);
  assign sda_w = !(o_sda_oe || ee_sda_low);

  acc_top #(.QTR_CYC(4)) DUT (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_lnk_clk(i_lnk_clk),
    .i_frame_valid(i_frame_valid), .i_frame(i_frame), .o_lnk_ready(o_lnk_ready),
    .o_smp_valid(o_smp_valid), .o_smp(o_smp), .o_cal_loaded(o_cal_loaded),
    .i_scl(scl_w), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe),
    .i_sda(sda_w), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe)
  );
  acc_eeprom_model EE (
    .i_scl(scl_w), .i_sda(sda_w), .o_scl_low(ee_scl_low), .o_sda_low(ee_sda_low)
  );

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // expected lane word for channel c
  function automatic logic [21:0] expv(input acc_frame_t f, input int c, input logic e);
    logic [15:0] o;
    logic [15:0] g;
    longint      v;
    o = {cal[4*c], cal[4*c+1]};
    g = {cal[4*c+2], cal[4*c+3]};
    v = longint'($signed(f[c])) * (131072 - longint'($signed(g)))
        - longint'($signed(o)) * 32768;
    v = (v + 65536) >>> 17;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return e ? {c[4:0], 1'b1, v[15:0]} : {c[4:0], 1'b0, f[c]};
  endfunction

  function automatic acc_frame_t rnd_frame();
    acc_frame_t f;
    for (int c = 0; c < NUM_CH; c++) f[c] = 16'($random(seed));
    return f;
  endfunction

  // offer a frame when ready, optionally a refused one after it
  task automatic send(input acc_frame_t f, input logic e, input logic junk);
    do @(negedge i_lnk_clk); while (o_lnk_ready !== 1'b1);
    fq.push_back(f);
    eq.push_back(e);
    i_frame = f;
    i_frame_valid = 1'b1;
    @(negedge i_lnk_clk);
    i_frame = ~f;
    i_frame_valid = junk;
    @(negedge i_lnk_clk);
    i_frame_valid = 1'b0;
    repeat (5) @(negedge i_lnk_clk);
  endtask

  // ------------------------------------------------
  // monitor and timeout
  // ------------------------------------------------
  always @(negedge i_ref_clk) begin
    if (o_smp_valid === 1'b1 && fq.size() == 0) begin
      check(32'h1, 32'h0);
    end else if (o_smp_valid === 1'b1) begin
      check(o_smp[0], expv(fq[0], 2*k, eq[0]));
      check(o_smp[1], expv(fq[0], 2*k+1, eq[0]));
      k++;
      if (k == 12) begin
        k = 0;
        void'(fq.pop_front());
        void'(eq.pop_front());
      end
    end
  end

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    for (int i = 0; i < EE_SIZE_BYTES; i++) EE.mem[i] = 8'($random(seed));
    for (int i = 0; i < 96; i++) cal[i] = 8'($random(seed));
    {cal[0], cal[1], cal[2], cal[3]} = 32'h7FFF8000;
    {cal[4], cal[5], cal[6], cal[7]} = 32'h7FFF7FFF;
    {cal[8], cal[9], cal[10], cal[11]} = 32'h80008000;
    {cal[12], cal[13], cal[14], cal[15]} = 32'h00000000;
    for (int i = 0; i < 96; i++) EE.mem[i] = cal[i];
    EE.refuse = 1; // first device select refused
    EE.stretch = 100; // slow memory
    repeat (5) @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    send(rnd_frame(), 1'b0, 1'b1);
    while (o_cal_loaded !== 1'b1) @(negedge i_ref_clk);
    check(EE.nread, 32'h60);
    check(EE.ptr, 32'h60);
    send({NUM_CH{16'h7FFF}}, 1'b1, 1'b0);
    send({NUM_CH{16'h8000}}, 1'b1, 1'b1);
    send('0, 1'b1, 1'b0);
    repeat (20) send(rnd_frame(), 1'b1, 1'($random(seed)));
    repeat (40) @(negedge i_ref_clk);
    check(fq.size(), 32'h0);
    report_and_stop();
  end
endmodule
